//--- hw/csp_cfg.svh
// Purpose: Constants of the cell secondary protector: offsets, fields, resets, timing.
// Assumes: pclk at 20 MHz; APB byte addresses; registers one aligned word each.
// Notes: Functional notes below give the behaviour kept by the protector.
//
// Functional notes
// R01 - A detected protection condition sets its per-source fault or alert flag.
// R02 - All fault flags OR into fault summary; alert flags OR into alert summary.
// R03 - Fault summary drives fault pin, alert summary drives alert pin, no host needed.
// R04 - Summaries and pins stay latched until host clears them by register write.
// R05 - Separate delay timers for overvoltage, undervoltage, overtemperature; 100 us to 12.7 s.
// R06 - Delay code zero: flag follows live comparator, not latched.
// R07 - Writing one to a flag clears it, its pin, and restarts its timer.
// R08 - Condition still present after clear reasserts flag when restarted timer expires.
// R09 - Leaving sleep blanks all comparators about 200 us before detection resumes.
// R10 - Over/undervoltage results of cells above configured count are ignored.
// R11 - Cell above threshold past overvoltage delay sets its bit; bits OR to flag.
// R12 - Cell below threshold past undervoltage delay sets its bit; bits OR to flag.
// R13 - Host removes cause, writes one then zero to clear a latched flag.
// R14 - Overvoltage thresholds step 50 mV, comparison uses hysteresis against chatter.
// R15 - Timers see a start-up deglitch up to 50 us before counting.
// R16 - Temperature input over threshold past delay sets its alert flag and pin.
// R17 - Each temperature threshold offers eleven non-linear trip steps plus disabled.
// R18 - Two temperature thresholds are separate; the delay setting is shared.
// R19 - Temperature code zero disables; codes 1 to 11 trip 40 to 90 C.
// R20 - Host sets thermistor power bit for temperature protection of that input.
// R21 - Fault input from the next higher device asserts this device's fault pin.
// R22 - Delay timer counts while condition persists, resets if condition goes away.
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH

`define CSP_ADDR_DEV_STATUS 6'h00
`define CSP_ADDR_FAULT 6'h01
`define CSP_ADDR_ALERT 6'h02
`define CSP_ADDR_CELL_OVER 6'h03
`define CSP_ADDR_CELL_UNDER 6'h04
`define CSP_ADDR_OV_THR 6'h05
`define CSP_ADDR_UV_THR 6'h06
`define CSP_ADDR_OV_DLY 6'h07
`define CSP_ADDR_UV_DLY 6'h08
`define CSP_ADDR_TA_THR 6'h09
`define CSP_ADDR_TB_THR 6'h0A
`define CSP_ADDR_T_DLY 6'h0B
`define CSP_ADDR_FUNC 6'h0C
`define CSP_ADDR_CTRL 6'h0D

`define CSP_BIT_OV 0
`define CSP_BIT_UV 1
`define CSP_BIT_SLEEP 0
`define CSP_BIT_TPWR_A 1
`define CSP_BIT_TPWR_B 2
`define CSP_DLY_LONG_BIT 7

`define CSP_RST_OV_THR 6'h28
`define CSP_RST_UV_THR 5'h0A
`define CSP_RST_DLY 8'h0A
`define CSP_RST_T_THR 4'h0
`define CSP_RST_FUNC 4'hC
`define CSP_RST_CTRL 3'h0

`define CSP_OV_BASE_MV 16'd2000
`define CSP_OV_STEP_MV 16'd50
`define CSP_UV_BASE_MV 16'd700
`define CSP_UV_STEP_MV 16'd100
`define CSP_HYST_MV 16'd50
`define CSP_OT_CODES 4'd11

`define CSP_CLK_MHZ 20
`define CSP_TICK_US 100
`define CSP_TICK_CYC (`CSP_TICK_US * `CSP_CLK_MHZ)
`define CSP_DEGLITCH_US 50
`define CSP_DEGLITCH_CYC (`CSP_DEGLITCH_US * `CSP_CLK_MHZ)
`define CSP_SETTLE_US 200
`define CSP_SETTLE_CYC (`CSP_SETTLE_US * `CSP_CLK_MHZ)
`define CSP_LONG_TICKS 17'd1000

`endif

//--- hw/csp_delay_timer.sv
// Purpose: Deglitch and delay timer for one protection condition.
// Assumes: tick is a one-cycle pulse every 100 us.
// Notes: Code bit 7 selects 100 ms units, else 100 us units.
`timescale 1ns/1ps
`include "csp_cfg.svh"
module csp_delay_timer (
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low
   input wire logic cond, // Live condition
   input wire logic restart, // Flag clear restarts the count
   input wire logic tick, // Timebase pulse
   input wire logic [7:0] delay_code, // Programmed delay
   output logic expired // One-cycle expiry pulse
);
   logic [10:0] glitch_reg;
   logic armed_reg;
   logic done_reg;
   logic [16:0] ticks_reg;
   logic [16:0] target;

   assign target = delay_code[`CSP_DLY_LONG_BIT] ?
      17'(delay_code[6:0]) * `CSP_LONG_TICKS : 17'(delay_code[6:0]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         glitch_reg <= 11'h000;
         armed_reg <= 1'b0;
         ticks_reg <= 17'h00000;
         done_reg <= 1'b0;
         expired <= 1'b0;
      end else if (!cond || restart) begin
         glitch_reg <= 11'h000; // R22
         armed_reg <= 1'b0;
         ticks_reg <= 17'h00000;
         done_reg <= 1'b0;
         expired <= 1'b0;
      end else if (!armed_reg) begin
         glitch_reg <= glitch_reg + 11'h001; // R15
         armed_reg <= (glitch_reg == 11'(`CSP_DEGLITCH_CYC - 1));
         expired <= 1'b0;
      end else if (tick && !done_reg) begin
         ticks_reg <= ticks_reg + 17'h00001;
         done_reg <= (ticks_reg + 17'h00001 >= target);
         expired <= (ticks_reg + 17'h00001 >= target); // R05
      end else begin
         expired <= 1'b0;
      end
   end

   drop_resets_a: assert property (@(posedge pclk) disable iff (!presetn)
      !cond |=> !expired && !armed_reg) // R22
      else $error("timer not reset when condition went away");
   deglitch_first_a: assert property (@(posedge pclk) disable iff (!presetn)
      expired |-> $past(armed_reg)) // R15
      else $error("timer expired before deglitch");
endmodule : csp_delay_timer

//--- hw/csp_hyst_cmp.sv
// Purpose: Comparator with hysteresis for one protection input.
// Assumes: Levels in the same unit as the value.
// Notes: Disabled comparator reads as not tripped.
`timescale 1ns/1ps
`include "csp_cfg.svh"
module csp_hyst_cmp #(
   parameter bit ABOVE = 1'b1
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low
   input wire logic enable, // Comparator powered
   input wire logic [15:0] value, // Sensed value
   input wire logic [15:0] set_lvl, // Trip level
   input wire logic [15:0] clr_lvl, // Release level
   output logic tripped // Condition present
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tripped <= 1'b0;
      end else if (!enable) begin
         tripped <= 1'b0;
      end else if (ABOVE) begin
         if (value > set_lvl) begin
            tripped <= 1'b1; // R14
         end else if (value < clr_lvl) begin
            tripped <= 1'b0;
         end
      end else begin
         if (value < set_lvl) begin
            tripped <= 1'b1;
         end else if (value > clr_lvl) begin
            tripped <= 1'b0;
         end
      end
   end
endmodule : csp_hyst_cmp

//--- hw/csp_pkg.sv
// Purpose: Types shared by the cell secondary protector.
// Assumes: Constants live in csp_cfg.svh.
// Notes: Sense values are digitised comparator inputs.
package csp_pkg;
   typedef enum logic [2:0] {
      CSP_RUN = 3'b001,
      CSP_SLEEP = 3'b010,
      CSP_SETTLE = 3'b100
   } csp_mode_e;

   typedef struct packed {
      logic [5:0][15:0] cell_mv;
      logic [1:0][15:0] temp_ratio;
   } csp_sense_s;
endpackage : csp_pkg

//--- hw/csp_protector.sv
// Purpose: Secondary protector: comparators, delay timers, latched flags, pins, APB regs.
// Assumes: Sense inputs and stack fault input synchronous to pclk.
// Notes: Pins follow the status flags one cycle later.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "csp_cfg.svh"
module csp_protector (
   input wire logic pclk, // 20 MHz clock
   input wire logic presetn, // Async reset, low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire csp_pkg::csp_sense_s sense, // Cell voltages and thermistor ratios
   input wire logic stack_fault_in, // Fault from next higher device
   output logic fault_out, // Fault pin, high active
   output logic alert_out, // Alert pin, high active
   output logic thermistor_power_a, // Thermistor A excitation
   output logic thermistor_power_b // Thermistor B excitation
);
   logic [5:0] overvoltage_threshold_cfg;
   logic [4:0] undervoltage_threshold_cfg;
   logic [7:0] overvoltage_delay_cfg;
   logic [7:0] undervoltage_delay_cfg;
   logic [1:0][3:0] temp_threshold_cfg;
   logic [7:0] temp_delay_cfg;
   logic [3:0] cell_count_field;
   logic [2:0] ctrl_reg;
   logic [5:0] per_cell_over_flags;
   logic [5:0] per_cell_under_flags;
   logic [1:0] overtemp_flags;
   logic [5:0] over_next;
   logic [5:0] under_next;
   logic [1:0] ot_next;
   logic [5:0] over_trip, under_trip, over_live, under_live, over_exp, under_exp;
   logic [1:0] ot_trip, ot_live, ot_exp;
   logic [5:0] cell_mask;
   logic [2:0] cells_used;
   logic [15:0] ov_set, ov_clr, uv_set, uv_clr;
   logic [1:0][15:0] ot_set, ot_clr;
   logic [1:0][31:0] ot_pair;
   logic [1:0] temp_power;
   logic cmp_enable;
   logic [10:0] tb_reg;
   logic tick_reg;
   csp_pkg::csp_mode_e mode_reg;
   logic [11:0] settle_reg;
   logic wr_en, access;
   logic [5:0] idx;
   logic clr_ov, clr_uv;
   logic [1:0] clr_ot;
   logic fault_sum, alert_sum;
   logic [31:0] rd_next;
   logic rd_err;

   // Ratios in 1/10000 of the excitation voltage
   function automatic logic [31:0] ot_levels(input logic [3:0] code);
      case (code)
         4'h1: ot_levels = {16'd2000, 16'd1766};
         4'h2: ot_levels = {16'd2244, 16'd2000};
         4'h3: ot_levels = {16'd2488, 16'd2270};
         4'h4: ot_levels = {16'd2712, 16'd2498};
         4'h5: ot_levels = {16'd2956, 16'd2750};
         4'h6: ot_levels = {16'd3156, 16'd2956};
         4'h7: ot_levels = {16'd3356, 16'd3162};
         4'h8: ot_levels = {16'd3556, 16'd3368};
         4'h9: ot_levels = {16'd3712, 16'd3528};
         4'hA: ot_levels = {16'd3866, 16'd3688};
         4'hB: ot_levels = {16'd4000, 16'd3824};
         default: ot_levels = {16'hFFFF, 16'hFFFF};
      endcase
   endfunction : ot_levels

   // Free timebase shared by all timers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tb_reg <= 11'h000;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= (tb_reg == 11'(`CSP_TICK_CYC - 1));
         tb_reg <= (tb_reg == 11'(`CSP_TICK_CYC - 1)) ? 11'h000 : tb_reg + 11'h001;
      end
   end

   // Sleep and post-sleep blanking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= csp_pkg::CSP_RUN;
         settle_reg <= 12'h000;
      end else begin
         case (mode_reg)
            csp_pkg::CSP_RUN: begin
               if (ctrl_reg[`CSP_BIT_SLEEP]) begin
                  mode_reg <= csp_pkg::CSP_SLEEP;
               end
            end
            csp_pkg::CSP_SLEEP: begin
               settle_reg <= 12'h000;
               if (!ctrl_reg[`CSP_BIT_SLEEP]) begin
                  mode_reg <= csp_pkg::CSP_SETTLE; // R09
               end
            end
            csp_pkg::CSP_SETTLE: begin
               settle_reg <= settle_reg + 12'h001;
               if (ctrl_reg[`CSP_BIT_SLEEP]) begin
                  mode_reg <= csp_pkg::CSP_SLEEP;
               end else if (settle_reg == 12'(`CSP_SETTLE_CYC - 1)) begin
                  mode_reg <= csp_pkg::CSP_RUN; // R09
               end
            end
            default: mode_reg <= csp_pkg::CSP_RUN;
         endcase
      end
   end

   assign cmp_enable = (mode_reg == csp_pkg::CSP_RUN); // R09

   // Levels; a zero-code sits at the base to keep arithmetic in range
   assign ov_set = `CSP_OV_BASE_MV + 16'(overvoltage_threshold_cfg) * `CSP_OV_STEP_MV; // R14
   assign ov_clr = ov_set - `CSP_HYST_MV; // R14
   assign uv_set = `CSP_UV_BASE_MV + 16'(undervoltage_threshold_cfg) * `CSP_UV_STEP_MV;
   assign uv_clr = uv_set + `CSP_HYST_MV;
   assign cells_used = (cell_count_field[3:1] == 3'h0 || cell_count_field[3:1] > 3'h6) ?
      3'h6 : cell_count_field[3:1];
   assign temp_power = {ctrl_reg[`CSP_BIT_TPWR_B], ctrl_reg[`CSP_BIT_TPWR_A]};

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_cell
         assign cell_mask[gi] = (3'(gi) < cells_used); // R10
         csp_hyst_cmp #(.ABOVE(1'b1)) u_ov_cmp (
            .pclk(pclk), .presetn(presetn), .enable(cmp_enable && cell_mask[gi]),
            .value(sense.cell_mv[gi]), .set_lvl(ov_set), .clr_lvl(ov_clr),
            .tripped(over_trip[gi]));
         csp_hyst_cmp #(.ABOVE(1'b0)) u_uv_cmp (
            .pclk(pclk), .presetn(presetn), .enable(cmp_enable && cell_mask[gi]),
            .value(sense.cell_mv[gi]), .set_lvl(uv_set), .clr_lvl(uv_clr),
            .tripped(under_trip[gi]));
         csp_delay_timer u_ov_tmr (
            .pclk(pclk), .presetn(presetn), .cond(over_live[gi]), .restart(clr_ov),
            .tick(tick_reg), .delay_code(overvoltage_delay_cfg), .expired(over_exp[gi]));
         csp_delay_timer u_uv_tmr (
            .pclk(pclk), .presetn(presetn), .cond(under_live[gi]), .restart(clr_uv),
            .tick(tick_reg), .delay_code(undervoltage_delay_cfg), .expired(under_exp[gi]));
      end
      for (gi = 0; gi < 2; gi++) begin : g_temp
         assign ot_pair[gi] = ot_levels(temp_threshold_cfg[gi]); // R17 R19
         assign ot_set[gi] = ot_pair[gi][31:16];
         assign ot_clr[gi] = ot_pair[gi][15:0];
         csp_hyst_cmp #(.ABOVE(1'b1)) u_ot_cmp (
            .pclk(pclk), .presetn(presetn),
            .enable(cmp_enable && temp_power[gi] && temp_threshold_cfg[gi] != 4'h0 &&
                    temp_threshold_cfg[gi] <= `CSP_OT_CODES), // R19 R20
            .value(sense.temp_ratio[gi]), .set_lvl(ot_set[gi]), .clr_lvl(ot_clr[gi]),
            .tripped(ot_trip[gi]));
         // Both inputs share one delay code
         csp_delay_timer u_ot_tmr (
            .pclk(pclk), .presetn(presetn), .cond(ot_live[gi]), .restart(clr_ot[gi]),
            .tick(tick_reg), .delay_code(temp_delay_cfg), .expired(ot_exp[gi])); // R18
      end
   endgenerate

   // Comparator state is dropped at once when blanked or masked
   assign over_live = over_trip & cell_mask & {6{cmp_enable}}; // R10
   assign under_live = under_trip & cell_mask & {6{cmp_enable}};
   assign ot_live = ot_trip & {2{cmp_enable}};

   // APB handshake: setup cycle loads the answer, access cycle completes
   assign access = psel && penable && pready;
   assign wr_en = access && pwrite && !pslverr;
   assign idx = paddr[7:2];
   assign clr_ov = wr_en && idx == `CSP_ADDR_FAULT && pwdata[`CSP_BIT_OV]; // R07
   assign clr_uv = wr_en && idx == `CSP_ADDR_FAULT && pwdata[`CSP_BIT_UV]; // R07
   assign clr_ot = (wr_en && idx == `CSP_ADDR_ALERT) ? pwdata[1:0] : 2'b00; // R07

   // Set beats clear; a zero delay makes the flag follow the comparator
   always_comb begin
      over_next = (per_cell_over_flags & ~{6{clr_ov}}) | over_exp; // R08 R11
      under_next = (per_cell_under_flags & ~{6{clr_uv}}) | under_exp; // R08 R12
      ot_next = (overtemp_flags & ~clr_ot) | ot_exp; // R16
      if (overvoltage_delay_cfg == 8'h00) begin
         over_next = over_live; // R06
      end
      if (undervoltage_delay_cfg == 8'h00) begin
         under_next = under_live; // R06
      end
      if (temp_delay_cfg == 8'h00) begin
         ot_next = ot_live; // R06
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_cell_over_flags <= 6'h00;
         per_cell_under_flags <= 6'h00;
         overtemp_flags <= 2'h0;
      end else begin
         per_cell_over_flags <= over_next; // R01 R04
         per_cell_under_flags <= under_next; // R01 R04
         overtemp_flags <= ot_next; // R01 R04
      end
   end

   assign fault_sum = |per_cell_over_flags || |per_cell_under_flags; // R02
   assign alert_sum = |overtemp_flags; // R02

   // Stack fault is not latched here; the higher device latches its own
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_out <= 1'b0;
         alert_out <= 1'b0;
      end else begin
         fault_out <= fault_sum || stack_fault_in; // R03 R21
         alert_out <= alert_sum; // R03
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overvoltage_threshold_cfg <= `CSP_RST_OV_THR;
         undervoltage_threshold_cfg <= `CSP_RST_UV_THR;
         overvoltage_delay_cfg <= `CSP_RST_DLY;
         undervoltage_delay_cfg <= `CSP_RST_DLY;
         temp_threshold_cfg <= {`CSP_RST_T_THR, `CSP_RST_T_THR};
         temp_delay_cfg <= `CSP_RST_DLY;
         cell_count_field <= `CSP_RST_FUNC;
         ctrl_reg <= `CSP_RST_CTRL;
      end else if (wr_en) begin
         case (idx)
            `CSP_ADDR_OV_THR: overvoltage_threshold_cfg <= pwdata[5:0];
            `CSP_ADDR_UV_THR: undervoltage_threshold_cfg <= pwdata[4:0];
            `CSP_ADDR_OV_DLY: overvoltage_delay_cfg <= pwdata[7:0];
            `CSP_ADDR_UV_DLY: undervoltage_delay_cfg <= pwdata[7:0];
            `CSP_ADDR_TA_THR: temp_threshold_cfg[0] <= pwdata[3:0];
            `CSP_ADDR_TB_THR: temp_threshold_cfg[1] <= pwdata[3:0];
            `CSP_ADDR_T_DLY: temp_delay_cfg <= pwdata[7:0];
            `CSP_ADDR_FUNC: cell_count_field <= pwdata[3:0];
            `CSP_ADDR_CTRL: ctrl_reg <= pwdata[2:0];
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   always_comb begin
      rd_next = 32'h0000_0000;
      rd_err = 1'b0;
      case (idx)
         `CSP_ADDR_DEV_STATUS: rd_next = {29'h0, mode_reg != csp_pkg::CSP_RUN,
                                          alert_sum, fault_sum}; // R02
         `CSP_ADDR_FAULT: rd_next = {30'h0, |per_cell_under_flags, |per_cell_over_flags};
         `CSP_ADDR_ALERT: rd_next = {30'h0, overtemp_flags};
         `CSP_ADDR_CELL_OVER: rd_next = {26'h0, per_cell_over_flags};
         `CSP_ADDR_CELL_UNDER: rd_next = {26'h0, per_cell_under_flags};
         `CSP_ADDR_OV_THR: rd_next = {26'h0, overvoltage_threshold_cfg};
         `CSP_ADDR_UV_THR: rd_next = {27'h0, undervoltage_threshold_cfg};
         `CSP_ADDR_OV_DLY: rd_next = {24'h0, overvoltage_delay_cfg};
         `CSP_ADDR_UV_DLY: rd_next = {24'h0, undervoltage_delay_cfg};
         `CSP_ADDR_TA_THR: rd_next = {28'h0, temp_threshold_cfg[0]};
         `CSP_ADDR_TB_THR: rd_next = {28'h0, temp_threshold_cfg[1]};
         `CSP_ADDR_T_DLY: rd_next = {24'h0, temp_delay_cfg};
         `CSP_ADDR_FUNC: rd_next = {28'h0, cell_count_field};
         `CSP_ADDR_CTRL: rd_next = {29'h0, ctrl_reg};
         default: rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         pslverr <= rd_err;
         prdata <= pwrite ? 32'h0000_0000 : rd_next;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thermistor_power_a <= 1'b0;
         thermistor_power_b <= 1'b0;
      end else begin
         thermistor_power_a <= ctrl_reg[`CSP_BIT_TPWR_A]; // R20
         thermistor_power_b <= ctrl_reg[`CSP_BIT_TPWR_B];
      end
   end

   sequence leave_sleep;
      mode_reg == csp_pkg::CSP_SLEEP ##1 mode_reg == csp_pkg::CSP_SETTLE;
   endsequence

   fault_pin_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
      ##1 fault_out == $past(fault_sum || stack_fault_in))
      else $error("fault pin does not follow fault summary");
   alert_pin_a: assert property (@(posedge pclk) disable iff (!presetn) // R16
      ##1 alert_out == $past(|overtemp_flags))
      else $error("alert pin does not follow alert flags");
   stack_fault_a: assert property (@(posedge pclk) disable iff (!presetn) // R21
      stack_fault_in |=> fault_out)
      else $error("stack fault not passed down");
   flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
      clr_ov && overvoltage_delay_cfg != 8'h00 && over_exp == 6'h00
      |=> per_cell_over_flags == 6'h00)
      else $error("overvoltage flags not cleared by write of one");
   flag_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
      per_cell_under_flags != 6'h00 && !clr_uv && undervoltage_delay_cfg != 8'h00
      && !(wr_en && idx == `CSP_ADDR_UV_DLY)
      |=> (per_cell_under_flags & $past(per_cell_under_flags)) == $past(per_cell_under_flags))
      else $error("latched undervoltage flag dropped without clear");
   zero_delay_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
      temp_delay_cfg == 8'h00 |=> overtemp_flags == $past(ot_live))
      else $error("zero delay flag does not follow comparator");
   cell_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
      ((per_cell_over_flags | per_cell_under_flags) & ~cell_mask) == 6'h00
      || $changed(cell_count_field) || $past(cell_count_field) != cell_count_field)
      else $error("flag set on an unused cell");
   sleep_blank_a: assert property (@(posedge pclk) disable iff (!presetn) // R09
      leave_sleep |-> (over_live == 6'h00 && under_live == 6'h00 && ot_live == 2'h0) [*8])
      else $error("comparators active during post-sleep blanking");
   expiry_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
      over_exp[0] && cmp_enable && overvoltage_delay_cfg != 8'h00 |=> per_cell_over_flags[0])
      else $error("expired overvoltage timer did not set cell flag");
   settle_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R09
      mode_reg == csp_pkg::CSP_SETTLE && settle_reg != 12'(`CSP_SETTLE_CYC - 1) |=> !cmp_enable)
      else $error("comparators enabled before settling ended");
   temp_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // R19
      ot_trip[0] |-> $past(temp_power[0] && temp_threshold_cfg[0] != 4'h0))
      else $error("temperature comparator tripped while off");
endmodule : csp_protector

//--- verification/csp_stack_peer.sv
// Purpose: Upper stacked device that drives the stack fault line.
// Assumes: Line is a registered level.
// Notes: Raises the line only when the bench commands it.
`timescale 1ns/1ps
module csp_stack_peer (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, low
   input wire logic raise, // Bench command
   output logic fault_line // To lower device
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) fault_line <= 1'b0;
      else fault_line <= raise;
   end
endmodule : csp_stack_peer

//--- verification/tb_top.sv
// Purpose: Self-checking bench of the protector.
// Assumes: Short delay codes keep the run brief.
// Notes: APB master holds each request until pready.
`timescale 1ns/1ps
`include "csp_cfg.svh"
module tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic raise = 1'b0, pready, pslverr, fo, ao, tpa, tpb, sfi, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   csp_pkg::csp_sense_s sense = '0;
   int fails = 0, checks = 0, cyc = 0;
   initial forever #25 pclk = ~pclk;
   csp_protector u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sense(sense), .stack_fault_in(sfi), .fault_out(fo),
      .alert_out(ao), .thermistor_power_a(tpa), .thermistor_power_b(tpb));
   csp_stack_peer u_peer (.pclk(pclk), .presetn(presetn), .raise(raise), .fault_line(sfi));
   task automatic wrap_up;
      if (fails == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
         fails++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input string nm, input logic [5:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(nm, rd, exp);
   endtask : rdc
   // Bounded wait; the pin level is judged by the caller
   task automatic wait_fo;
      repeat (8000) begin
         @(posedge pclk);
         if (fo === 1'b1) break;
      end
   endtask : wait_fo
   task automatic t_reset;
      rdc("ov_thr", `CSP_ADDR_OV_THR, 32'h28);
      rdc("func", `CSP_ADDR_FUNC, 32'hC);
      rdc("ctrl", `CSP_ADDR_CTRL, 32'h0);
      apb(1'b0, 6'h3F, 32'h0);
      chk("slverr", {31'h0, err}, 32'h1);
   endtask : t_reset
   task automatic t_live;
      apb(1'b1, `CSP_ADDR_OV_DLY, 32'h0);
      apb(1'b1, `CSP_ADDR_UV_DLY, 32'h0);
      sense.cell_mv[0] <= 16'h1004;
      sense.cell_mv[1] <= 16'h05DC;
      repeat (5) @(posedge pclk);
      rdc("fault", `CSP_ADDR_FAULT, 32'h3);
      rdc("dev_st", `CSP_ADDR_DEV_STATUS, 32'h1);
      chk("fo_on", {31'h0, fo}, 32'h1);
      sense.cell_mv[0] <= 16'h0BB8;
      sense.cell_mv[1] <= 16'h0BB8;
      repeat (5) @(posedge pclk);
      rdc("fault_off", `CSP_ADDR_FAULT, 32'h0);
   endtask : t_live
   task automatic t_count;
      apb(1'b1, `CSP_ADDR_FUNC, 32'h8);
      sense.cell_mv[4] <= 16'h1004;
      repeat (5) @(posedge pclk);
      rdc("ign", `CSP_ADDR_FAULT, 32'h0);
      sense.cell_mv[3] <= 16'h1004;
      repeat (5) @(posedge pclk);
      rdc("cell4", `CSP_ADDR_CELL_OVER, 32'h8);
      sense.cell_mv[3] <= 16'h0BB8;
      sense.cell_mv[4] <= 16'h0BB8;
      apb(1'b1, `CSP_ADDR_FUNC, 32'hC);
   endtask : t_count
   task automatic t_latch;
      apb(1'b1, `CSP_ADDR_OV_DLY, 32'h1);
      sense.cell_mv[2] <= 16'h1004;
      repeat (900) @(posedge pclk);
      chk("early", {31'h0, fo}, 32'h0);
      wait_fo();
      chk("expire", {31'h0, fo}, 32'h1);
      apb(1'b1, `CSP_ADDR_FAULT, 32'h1);
      repeat (2) @(posedge pclk);
      chk("clr", {31'h0, fo}, 32'h0);
      wait_fo();
      chk("again", {31'h0, fo}, 32'h1);
      sense.cell_mv[2] <= 16'h0BB8;
      repeat (5) @(posedge pclk);
      rdc("held", `CSP_ADDR_CELL_OVER, 32'h4);
      apb(1'b1, `CSP_ADDR_FAULT, 32'h1);
      apb(1'b1, `CSP_ADDR_FAULT, 32'h0);
      repeat (3) @(posedge pclk);
      chk("gone", {31'h0, fo}, 32'h0);
   endtask : t_latch
   task automatic t_temp;
      apb(1'b1, `CSP_ADDR_CTRL, 32'h6);
      apb(1'b1, `CSP_ADDR_TA_THR, 32'h1);
      apb(1'b1, `CSP_ADDR_T_DLY, 32'h0);
      sense.temp_ratio[0] <= 16'h09C4;
      repeat (5) @(posedge pclk);
      rdc("alert", `CSP_ADDR_ALERT, 32'h1);
      chk("ao", {29'h0, tpb, tpa, ao}, 32'h7);
      rdc("dev_al", `CSP_ADDR_DEV_STATUS, 32'h2);
      sense.temp_ratio[0] <= 16'h0000;
      repeat (5) @(posedge pclk);
      chk("ao_off", {31'h0, ao}, 32'h0);
   endtask : t_temp
   task automatic t_stack_sleep;
      raise <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("stack", {31'h0, fo}, 32'h1);
      raise <= 1'b0;
      apb(1'b1, `CSP_ADDR_OV_DLY, 32'h0);
      apb(1'b1, `CSP_ADDR_CTRL, 32'h1);
      sense.cell_mv[0] <= 16'h1004;
      repeat (5) @(posedge pclk);
      chk("asleep", {31'h0, fo}, 32'h0);
      apb(1'b1, `CSP_ADDR_CTRL, 32'h0);
      repeat (100) @(posedge pclk);
      chk("settle", {31'h0, fo}, 32'h0);
      rdc("blank", `CSP_ADDR_DEV_STATUS, 32'h4);
      repeat (4100) @(posedge pclk);
      chk("resume", {31'h0, fo}, 32'h1);
   endtask : t_stack_sleep
   initial begin
      for (int i = 0; i < 6; i++) sense.cell_mv[i] = 16'h0BB8;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_live();
      t_count();
      t_latch();
      t_temp();
      t_stack_sleep();
      wrap_up();
   end
endmodule : tb_top
